// [lsd_pkg.sv]
// Purpose: Constants shared by the low-side driver control block.
// Assumes: 8-bit registers reached over the die-to-die bus, 16-bit global address.
// Notes:   Every offset, bit position and reset value used by the logic lives here.
//
// What this block does
// - Control bits 0 and 1 switch driver one and two, only while unlocked.
// - Control bits 2 and 3 select PWM drive instead of plain on/off.
// - Control bits 4 and 5 route PWM channel 0 or 1 to each driver.
// - Control bit 7 enables overtemperature interrupt; bit 6 reads zero.
// - Status bit 7 shows overtemperature, drivers held off; bits 6..4 read zero.
// - Reading the status register clears the pending overtemperature interrupt flag.
// - Status bits 3 and 2 show current limitation of driver two and one.
// - Status bits 1 and 0 show open load of driver two and one.
// - Open load is never reported while a driver is off, PWM off phase included.
// - Key field bits 3..0 unlock control only at 0x5; upper bits read zero.
// - Drivers switch off whenever a regulator is in overvoltage.
// - An overvoltage event clears both driver on/off control bits.
// - Overvoltage flag follows the condition; enabled interrupt cleared by reading flag.
// - A new overvoltage interrupt needs the condition to leave and return.
// - Overtemperature shuts both drivers off and latches a low-side interrupt source.
// - The latched overtemperature event requests an interrupt only when masked in.
// - After overtemperature, drivers stay off until a control write with condition gone.
// - Registers decode at base 0x0200 blocking and 0x300 non-blocking.
// - Drivers run only in Normal mode; forced off in Sleep and Stop.

package lsd_pkg;

    // -------------------------------------------------------------------
    // Bus geometry and address map
    // -------------------------------------------------------------------
    localparam int          LSD_ADDR_W        = 16;
    localparam int          LSD_DATA_W        = 8;
    localparam logic [15:0] LSD_BASE_BLOCKING = 16'h0200;
    localparam logic [15:0] LSD_BASE_NONBLOCK = 16'h0300;
    localparam logic [15:0] LSD_OFF_CONTROL   = 16'h0030;
    localparam logic [15:0] LSD_OFF_STATUS    = 16'h0031;
    localparam logic [15:0] LSD_OFF_KEY       = 16'h0032;

    // -------------------------------------------------------------------
    // Control register fields
    // -------------------------------------------------------------------
    localparam int LSD_CTL_ON_LSB      = 0;  // driver_one_on, driver_two_on
    localparam int LSD_CTL_PWM_ON_LSB  = 2;  // driver_one_pwm_on, driver_two_pwm_on
    localparam int LSD_CTL_PWM_SRC_LSB = 4;  // driver_one/two_pwm_source
    localparam int LSD_CTL_OT_IRQ_EN   = 7;  // overtemp_irq_enable

    // -------------------------------------------------------------------
    // Status register fields
    // -------------------------------------------------------------------
    localparam int LSD_STS_OPEN_LOAD_LSB = 0;
    localparam int LSD_STS_CUR_LIM_LSB   = 2;
    localparam int LSD_STS_OVERTEMP      = 7;

    // -------------------------------------------------------------------
    // Key register and reset values
    // -------------------------------------------------------------------
    localparam int         LSD_KEY_W      = 4;
    localparam logic [3:0] LSD_KEY_UNLOCK = 4'h5;
    localparam logic [3:0] LSD_KEY_RESET  = 4'h0;
    localparam logic [7:0] LSD_REG_RESET  = 8'h00;

    // -------------------------------------------------------------------
    // Analog inputs passed through the synchroniser, by position
    // -------------------------------------------------------------------
    localparam int LSD_NUM_DRV      = 2;
    localparam int LSD_SYN_W        = 6;
    localparam int LSD_SYN_OT       = 0;
    localparam int LSD_SYN_OV       = 1;
    localparam int LSD_SYN_CL_LSB   = 2;  // two current-limit bits
    localparam int LSD_SYN_OL_LSB   = 4;  // two open-load bits

    // Address match against both windows of the global map
    function automatic logic lsd_hit(input logic [15:0] addr, input logic [15:0] off);
        lsd_hit = (addr == (LSD_BASE_BLOCKING + off)) || (addr == (LSD_BASE_NONBLOCK + off));
    endfunction

endpackage

// [lsd_sync.sv]
// Purpose: Two-flop synchroniser for the analog status levels.
// Assumes: Inputs are slow levels from the analog section.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/10ps
`default_nettype none

module lsd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } lsd_sync_state_t;

    lsd_sync_state_t st;
    lsd_sync_state_t next_st;

    // Shift chain; stage1 feeds stage2 only
    always_comb begin
        next_st.stage1 = async_in;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stage2;

endmodule
`default_nettype wire

// [lsd_channel.sv]
// Purpose: Gate drive and open-load qualification for one low-side driver.
// Assumes: PWM waveforms come from logic on the same clock.
// Notes:   The enable input already folds in key, mode and all fault holds.
`timescale 1ns/10ps
`default_nettype none

module lsd_channel (
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    input  wire logic       enable_in,
    input  wire logic       on_in,
    input  wire logic       pwm_on_in,
    input  wire logic       pwm_source_in,
    input  wire logic [1:0] pwm_in,
    input  wire logic       open_load_in,
    output logic            gate_out,
    output logic            open_load_out
);

    typedef struct packed {
        logic gate;
        logic open_load;
    } lsd_chan_state_t;

    lsd_chan_state_t st;
    lsd_chan_state_t next_st;

    // Demand is PWM or plain bit; open load only counts while the gate is on
    always_comb begin
        logic demand;
        demand            = pwm_on_in ? pwm_in[pwm_source_in] : on_in;
        next_st.gate      = enable_in & demand;
        next_st.open_load = open_load_in & next_st.gate;
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign gate_out      = st.gate;
    assign open_load_out = st.open_load;

endmodule
`default_nettype wire

// [lsd_top.sv]
// Purpose: Register file and protection logic for two low-side relay drivers.
// Assumes: Simple die-to-die register port; analog faults arrive asynchronously.
// Notes:   Read data appear one clock after the read strobe, with a valid pulse.
`timescale 1ns/10ps
`default_nettype none

module lsd_top
    import lsd_pkg::*;
(
    input  wire logic                  mclk_in,
    input  wire logic                  reset_in,
    // Die-to-die register port
    input  wire logic [LSD_ADDR_W-1:0] bus_addr_in,
    input  wire logic                  bus_write_in,
    input  wire logic                  bus_read_in,
    input  wire logic [LSD_DATA_W-1:0] bus_wdata_in,
    output logic      [LSD_DATA_W-1:0] bus_rdata_out,
    output logic                       bus_rvalid_out,
    // Internal PWM channels 0 and 1
    input  wire logic [1:0]            pwm_in,
    // Power mode from the mode controller
    input  wire logic                  normal_mode_in,
    // Analog sense levels
    input  wire logic                  overtemp_in,
    input  wire logic                  regulator_overvoltage_in,
    input  wire logic [1:0]            current_limited_in,
    input  wire logic [1:0]            open_load_in,
    // Voltage status side
    input  wire logic                  regulator_overvoltage_irq_enable_in,
    input  wire logic                  overvoltage_flag_read_in,
    output logic                       regulator_overvoltage_flag_out,
    output logic                       overvoltage_irq_out,
    // Interrupt control side
    input  wire logic                  low_side_irq_mask_in,
    output logic                       overtemp_source_out,
    output logic                       overtemp_irq_out,
    // Driver gates
    output logic      [1:0]            driver_gate_out
);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        logic                  ot_irq_en;
        logic [1:0]            pwm_src;
        logic [1:0]            pwm_on;
        logic [1:0]            drv_on;
        logic [LSD_KEY_W-1:0]  key;
        logic                  ot_flag;
        logic                  ov_irq;
        logic                  ov_prev;
        logic                  ot_prev;
        logic                  ot_lockout;
        logic [LSD_DATA_W-1:0] rdata;
        logic                  rvalid;
    } lsd_state_t;

    lsd_state_t st;
    lsd_state_t next_st;

    logic [LSD_SYN_W-1:0]   syn;
    logic [1:0]             gate;
    logic [1:0]             ol_qual;
    logic                   ot_now;
    logic                   ov_now;
    logic                   hit_ctl;
    logic                   hit_sts;
    logic                   hit_key;
    logic                   unlocked;
    logic                   drive_allowed;
    logic [LSD_DATA_W-1:0]  ctl_view;
    logic [LSD_DATA_W-1:0]  sts_view;
    logic [LSD_DATA_W-1:0]  key_view;

    // -------------------------------------------------------------------
    // Analog inputs into the clock domain
    // -------------------------------------------------------------------
    lsd_sync #(
        .WIDTH (LSD_SYN_W)
    ) u_sync (
        .mclk_in  (mclk_in),
        .reset_in (reset_in),
        .async_in ({open_load_in, current_limited_in, regulator_overvoltage_in, overtemp_in}),
        .sync_out (syn)
    );

    assign ot_now = syn[LSD_SYN_OT];
    assign ov_now = syn[LSD_SYN_OV];

    // -------------------------------------------------------------------
    // Address decode and register views
    // -------------------------------------------------------------------
    // Same three offsets answer in both windows
    always_comb begin
        hit_ctl = 1'b0;
        hit_sts = 1'b0;
        hit_key = 1'b0;
        if (lsd_hit(bus_addr_in, LSD_OFF_CONTROL)) begin
            hit_ctl = 1'b1;
        end else if (lsd_hit(bus_addr_in, LSD_OFF_STATUS)) begin
            hit_sts = 1'b1;
        end else if (lsd_hit(bus_addr_in, LSD_OFF_KEY)) begin
            hit_key = 1'b1;
        end
    end

    // Unused bits are packed as zero
    always_comb begin
        ctl_view                                  = LSD_REG_RESET;
        ctl_view[LSD_CTL_ON_LSB +: 2]             = st.drv_on;
        ctl_view[LSD_CTL_PWM_ON_LSB +: 2]         = st.pwm_on;
        ctl_view[LSD_CTL_PWM_SRC_LSB +: 2]        = st.pwm_src;
        ctl_view[LSD_CTL_OT_IRQ_EN]               = st.ot_irq_en;
        sts_view                                  = LSD_REG_RESET;
        sts_view[LSD_STS_OPEN_LOAD_LSB +: 2]      = ol_qual;
        sts_view[LSD_STS_CUR_LIM_LSB +: 2]        = syn[LSD_SYN_CL_LSB +: 2];
        sts_view[LSD_STS_OVERTEMP]                = ot_now;
        key_view                                  = LSD_REG_RESET;
        key_view[LSD_KEY_W-1:0]                   = st.key;
    end

    // -------------------------------------------------------------------
    // Drive permission
    // -------------------------------------------------------------------
    // Gate is the AND of every hold; a stale key, overtemperature or overvoltage forces both off
    assign unlocked      = (st.key == LSD_KEY_UNLOCK);
    assign drive_allowed = unlocked
                         & normal_mode_in
                         & ~ot_now
                         & ~st.ot_lockout
                         & ~ov_now;

    // -------------------------------------------------------------------
    // Per-driver channels
    // -------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < LSD_NUM_DRV; gi++) begin : g_drv
            lsd_channel u_chan (
                .mclk_in       (mclk_in),
                .reset_in      (reset_in),
                .enable_in     (drive_allowed),
                .on_in         (st.drv_on[gi]),
                .pwm_on_in     (st.pwm_on[gi]),
                .pwm_source_in (st.pwm_src[gi]),
                .pwm_in        (pwm_in),
                .open_load_in  (syn[LSD_SYN_OL_LSB + gi]),
                .gate_out      (gate[gi]),
                .open_load_out (ol_qual[gi])
            );
        end
    endgenerate

    // -------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------
    // Hardware events are applied after software writes so that they win
    always_comb begin
        logic wr_ctl;
        logic wr_key;
        logic rd_sts;
        logic ot_rise;
        logic ov_rise;
        wr_ctl  = bus_write_in & hit_ctl;
        wr_key  = bus_write_in & hit_key;
        rd_sts  = bus_read_in & hit_sts;
        ot_rise = ot_now & ~st.ot_prev;
        ov_rise = ov_now & ~st.ov_prev;

        next_st         = st;
        next_st.ot_prev = ot_now;
        next_st.ov_prev = ov_now;

        // Control write; status writes fall through with no effect
        if (wr_ctl) begin
            next_st.drv_on    = bus_wdata_in[LSD_CTL_ON_LSB +: 2];
            next_st.pwm_on    = bus_wdata_in[LSD_CTL_PWM_ON_LSB +: 2];
            next_st.pwm_src   = bus_wdata_in[LSD_CTL_PWM_SRC_LSB +: 2];
            next_st.ot_irq_en = bus_wdata_in[LSD_CTL_OT_IRQ_EN];
            if (!ot_now) begin
                next_st.ot_lockout = 1'b0;
            end
        end
        if (wr_key) begin
            next_st.key = bus_wdata_in[LSD_KEY_W-1:0];
        end

        // Overtemperature: lock out drivers, latch the interrupt source
        if (rd_sts) begin
            next_st.ot_flag = 1'b0;
        end
        if (ot_now) begin
            next_st.ot_lockout = 1'b1;
        end
        if (ot_rise && st.ot_irq_en) begin
            next_st.ot_flag = 1'b1;
        end

        // Overvoltage: drop on bits and the key, edge-triggered interrupt
        if (overvoltage_flag_read_in) begin
            next_st.ov_irq = 1'b0;
        end
        if (ov_rise) begin
            next_st.drv_on = 2'h0;
            next_st.key    = LSD_KEY_RESET;
            if (regulator_overvoltage_irq_enable_in) begin
                next_st.ov_irq = 1'b1;
            end
        end

        // Registered read answer; unmapped addresses read zero
        next_st.rvalid = bus_read_in;
        if (!bus_read_in) begin
            next_st.rdata = st.rdata;
        end else if (hit_ctl) begin
            next_st.rdata = ctl_view;
        end else if (hit_sts) begin
            next_st.rdata = sts_view;
        end else if (hit_key) begin
            next_st.rdata = key_view;
        end else begin
            next_st.rdata = LSD_REG_RESET;
        end
    end

    // -------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            st     <= '0;
            st.key <= LSD_KEY_RESET;
        end else begin
            st <= next_st;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign bus_rdata_out                  = st.rdata;
    assign bus_rvalid_out                 = st.rvalid;
    assign driver_gate_out                = gate;
    assign regulator_overvoltage_flag_out = ov_now;
    assign overvoltage_irq_out            = st.ov_irq;
    assign overtemp_source_out            = st.ot_flag;
    assign overtemp_irq_out               = st.ot_flag & low_side_irq_mask_in;

endmodule
`default_nettype wire

// [lsd_load.sv]
// Purpose: Behavioural relay load pair seen by the two low-side gates.
// Assumes: Sense levels follow the gates at once; the block synchronises them.
// Notes:   An off driver carries no current, so raw open load reads high then.
`timescale 1ns/10ps
`default_nettype none

module lsd_load (
    input  wire logic [1:0] gate_in,
    input  wire logic [1:0] open_cfg_in,
    input  wire logic [1:0] short_cfg_in,
    output logic      [1:0] open_load_out,
    output logic      [1:0] current_limited_out
);
    // No current below threshold when off: not kind to the qualifier
    assign open_load_out       = open_cfg_in | ~gate_in;
    // Limitation only while the shorted driver conducts
    assign current_limited_out = short_cfg_in & gate_in;
endmodule

`default_nettype wire

// [lsd_top_chk.sv]
// Purpose: Port-level checks for the low-side driver control block.
// Assumes: Fault inputs pass a two-flop synchroniser before use.
// Notes:   Bound to lsd_top at the foot of this file.
`timescale 1ns/10ps
`default_nettype none

module lsd_top_chk
    import lsd_pkg::*;
(
    input wire logic        mclk_in,
    input wire logic        reset_in,
    input wire logic [15:0] bus_addr_in,
    input wire logic        bus_read_in,
    input wire logic [7:0]  bus_rdata_out,
    input wire logic        bus_rvalid_out,
    input wire logic        normal_mode_in,
    input wire logic        overtemp_in,
    input wire logic        regulator_overvoltage_irq_enable_in,
    input wire logic        overvoltage_flag_read_in,
    input wire logic        regulator_overvoltage_flag_out,
    input wire logic        overvoltage_irq_out,
    input wire logic        low_side_irq_mask_in,
    input wire logic        overtemp_source_out,
    input wire logic        overtemp_irq_out,
    input wire logic [1:0]  driver_gate_out
);
    // ----------------------------------------------------------------
    // Decode, sequences and properties
    // ----------------------------------------------------------------
    logic rd_win, ctl_rd, st_rd, key_rd;
    // Reads in either window
    assign rd_win = bus_read_in && bus_addr_in[15:9] == 7'h01;
    assign ctl_rd = rd_win && bus_addr_in[7:0] == 8'h30;
    assign st_rd  = rd_win && bus_addr_in[7:0] == 8'h31;
    assign key_rd = rd_win && bus_addr_in[7:0] == 8'h32;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    // Held three edges so the synchroniser has surely passed it
    sequence s_ot_held;
        overtemp_in [*3];
    endsequence
    // Synced input has no rising edge at the read
    sequence s_ot_steady;
        $past(overtemp_in, 2) == $past(overtemp_in, 3);
    endsequence

    property p_rvalid;
        bus_read_in |=> bus_rvalid_out;
    endproperty
    property p_ctl_bit6;
        ctl_rd |=> bus_rdata_out[6] == 1'b0;
    endproperty
    property p_sts_zero;
        st_rd |=> bus_rdata_out[6:4] == 3'h0;
    endproperty
    property p_key_upper;
        key_rd |=> bus_rdata_out[7:4] == 4'h0;
    endproperty
    property p_ot_off;
        s_ot_held |=> driver_gate_out == 2'b00;
    endproperty
    property p_mode;
        !normal_mode_in |=> driver_gate_out == 2'b00;
    endproperty
    property p_ov_off;
        regulator_overvoltage_flag_out |=> driver_gate_out == 2'b00;
    endproperty
    property p_irq_mask;
        overtemp_irq_out == (overtemp_source_out && low_side_irq_mask_in);
    endproperty
    property p_st_clear;
        s_ot_steady ##0 st_rd |=> !overtemp_source_out;
    endproperty
    property p_ov_rise;
        $rose(regulator_overvoltage_flag_out) && regulator_overvoltage_irq_enable_in
            |=> overvoltage_irq_out;
    endproperty
    property p_ov_persist;
        overvoltage_flag_read_in && regulator_overvoltage_flag_out
            && $past(regulator_overvoltage_flag_out) |=> !overvoltage_irq_out;
    endproperty

    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    a_ctl_bit6: assert property (p_ctl_bit6) else $error("control bit 6 set");
    a_sts_zero: assert property (p_sts_zero) else $error("status 6..4 set");
    a_key_upper: assert property (p_key_upper) else $error("key upper set");
    a_ot_off: assert property (p_ot_off) else $error("gate on in overtemp");
    a_mode: assert property (p_mode) else $error("gate on outside normal");
    a_ov_off: assert property (p_ov_off) else $error("gate on in overvoltage");
    a_irq_mask: assert property (p_irq_mask) else $error("overtemp irq mask");
    a_st_clear: assert property (p_st_clear) else $error("source not cleared");
    a_ov_rise: assert property (p_ov_rise) else $error("no overvoltage irq");
    a_ov_persist: assert property (p_ov_persist) else $error("irq repeated");
endmodule

bind lsd_top lsd_top_chk chk (.*);

`default_nettype wire

// [low_side_driver_control_bench.sv]
// Purpose: Self-checking bench for the low-side driver control block.
// Assumes: Inputs change on the falling edge; read data one cycle after strobe.
// Notes:   Relay loads come from lsd_load; faults are driven by the bench.
`timescale 1ns/10ps
`default_nettype none

module low_side_driver_control_bench;
    import lsd_pkg::*;
    localparam logic [15:0] A_CTL = LSD_BASE_BLOCKING + LSD_OFF_CONTROL;
    localparam logic [15:0] A_STS = LSD_BASE_BLOCKING + LSD_OFF_STATUS;
    localparam logic [15:0] A_KEY = LSD_BASE_BLOCKING + LSD_OFF_KEY;
    localparam logic [15:0] N_OFF = LSD_BASE_NONBLOCK - LSD_BASE_BLOCKING;
    logic mclk_in = 1'b0, reset_in = 1'b1, bus_write_in = 1'b0, bus_read_in = 1'b0;
    logic [15:0] bus_addr_in = '0;
    logic [7:0] bus_wdata_in = '0, bus_rdata_out;
    logic [1:0] pwm_in = '0, current_limited_in, open_load_in, driver_gate_out;
    logic [1:0] open_cfg = '0, short_cfg = '0;
    logic normal_mode_in = 1'b1, overtemp_in = 1'b0, regulator_overvoltage_in = 1'b0;
    logic regulator_overvoltage_irq_enable_in = 1'b1, overvoltage_flag_read_in = 1'b0;
    logic low_side_irq_mask_in = 1'b0, bus_rvalid_out, regulator_overvoltage_flag_out;
    logic overvoltage_irq_out, overtemp_source_out, overtemp_irq_out;
    int fail_count = 0;
    int checked = 0;

    lsd_top dut (.*);
    lsd_load load (.gate_in(driver_gate_out), .open_cfg_in(open_cfg),
        .short_cfg_in(short_cfg), .open_load_out(open_load_in),
        .current_limited_out(current_limited_in));

    // 20 MHz clock
    always #25 mclk_in = ~mclk_in;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    // One-cycle write strobe; ends low so the next call waits an edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        bus_addr_in = a;
        bus_wdata_in = d;
        bus_write_in = 1'b1;
        @(negedge mclk_in);
        bus_write_in = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(negedge mclk_in);
        bus_addr_in = a;
        bus_read_in = 1'b1;
        @(negedge mclk_in);
        bus_read_in = 1'b0;
        bit_is("rvalid", bus_rvalid_out, 1'b1);
        check(what, bus_rdata_out, exp);
    endtask
    task automatic gate_is(input logic [1:0] exp);
        check("gate", {6'h0, driver_gate_out}, {6'h0, exp});
    endtask
    task automatic bit_is(input string what, input logic seen, input logic exp);
        check(what, {7'h0, seen}, {7'h0, exp});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_and_map;
        rd(A_CTL, LSD_REG_RESET, "control");
        rd(A_STS + N_OFF, LSD_REG_RESET, "status");
        rd(A_KEY, LSD_REG_RESET, "key");
        rd(16'h0233, 8'h00, "unmapped");
        rd(16'h0130, 8'h00, "foreign base");
    endtask
    task automatic t_key;
        wr(A_CTL, 8'h03);
        cyc(3);
        gate_is(2'b00);
        wr(A_KEY, 8'hfa);
        rd(A_KEY, 8'h0a, "key");
        gate_is(2'b00);
        wr(A_KEY + N_OFF, 8'h05);
        cyc(3);
        gate_is(2'b11);
        wr(A_CTL, 8'hff);
        rd(A_CTL + N_OFF, 8'hbf, "control");
        wr(A_STS, 8'hff);
        rd(A_STS, 8'h00, "status");
    endtask
    task automatic t_pwm;
        for (int s = 0; s < 4; s++) begin
            wr(A_CTL, {2'b00, s[1:0], 4'b1100});
            for (int p = 0; p < 4; p++) begin
                pwm_in = p[1:0];
                cyc(2);
                gate_is({pwm_in[s[1]], pwm_in[s[0]]});
            end
        end
        pwm_in = 2'b00;
        wr(A_CTL, 8'h06);
        cyc(2);
        gate_is(2'b10);
    endtask
    task automatic t_status;
        open_cfg = 2'b01;
        short_cfg = 2'b10;
        wr(A_CTL, 8'h03);
        cyc(4);
        rd(A_STS, 8'h09, "status");
        open_cfg = 2'b10;
        short_cfg = 2'b01;
        cyc(4);
        rd(A_STS, 8'h06, "status");
        open_cfg = 2'b00;
        short_cfg = 2'b00;
        wr(A_CTL, 8'h04);
        cyc(4);
        rd(A_STS, 8'h00, "status pwm off phase");
    endtask
    task automatic t_overtemp;
        wr(A_CTL, 8'h83);
        overtemp_in = 1'b1;
        cyc(5);
        gate_is(2'b00);
        bit_is("ot source", overtemp_source_out, 1'b1);
        bit_is("ot irq", overtemp_irq_out, 1'b0);
        low_side_irq_mask_in = 1'b1;
        cyc(1);
        bit_is("ot irq", overtemp_irq_out, 1'b1);
        rd(A_STS, 8'h80, "status");
        bit_is("ot source", overtemp_source_out, 1'b0);
        wr(A_CTL, 8'h83);
        cyc(3);
        gate_is(2'b00);
        overtemp_in = 1'b0;
        cyc(5);
        gate_is(2'b00);
        wr(A_CTL, 8'h83);
        cyc(3);
        gate_is(2'b11);
    endtask
    task automatic t_overvoltage;
        regulator_overvoltage_in = 1'b1;
        cyc(5);
        gate_is(2'b00);
        bit_is("ov irq", overvoltage_irq_out, 1'b1);
        bit_is("ov flag", regulator_overvoltage_flag_out, 1'b1);
        rd(A_CTL, 8'h80, "control");
        overvoltage_flag_read_in = 1'b1;
        cyc(1);
        overvoltage_flag_read_in = 1'b0;
        cyc(3);
        bit_is("ov irq", overvoltage_irq_out, 1'b0);
        regulator_overvoltage_in = 1'b0;
        cyc(4);
        wr(A_CTL, 8'h03);
        cyc(3);
        gate_is(2'b00);
        wr(A_KEY, 8'h05);
        wr(A_CTL, 8'h03);
        cyc(3);
        gate_is(2'b11);
        regulator_overvoltage_in = 1'b1;
        cyc(5);
        bit_is("ov irq", overvoltage_irq_out, 1'b1);
        regulator_overvoltage_in = 1'b0;
    endtask
    task automatic t_mode;
        wr(A_KEY, 8'h05);
        wr(A_CTL, 8'h03);
        normal_mode_in = 1'b0;
        cyc(3);
        gate_is(2'b00);
        normal_mode_in = 1'b1;
        cyc(2);
        gate_is(2'b11);
    endtask

    // ----------------------------------------------------------------
    // Verdict, sequence and watchdog
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        cyc(16);
        reset_in = 1'b0;
        t_reset_and_map();
        t_key();
        t_pwm();
        t_status();
        t_overtemp();
        t_overvoltage();
        t_mode();
        report_and_stop();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #150000;
        fail_count++;
        report_and_stop();
    end
endmodule

`default_nettype wire
